/* verilog/hvp_pkg.sv */
// Shared constants and types of the high-voltage serial programming port
package hvp_pkg;

  // ==========================================================
  // Link framing
  localparam int FRAME_BITS = 11;
  localparam int CLK_NS = 25;

  // ==========================================================
  // Device timing
  localparam int T_HV_LATCH_NS = 100;
  localparam int HV_LATCH_CYC = (T_HV_LATCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_WD_FLASH_NS = 4500000;
  localparam int T_WD_EEPROM_NS = 3600000;
  localparam int T_WD_ERASE_NS = 9000000;
  localparam int FLASH_CYC = (T_WD_FLASH_NS + CLK_NS - 1) / CLK_NS;
  localparam int EE_CYC = (T_WD_EEPROM_NS + CLK_NS - 1) / CLK_NS;
  localparam int ERASE_CYC = (T_WD_ERASE_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================
  // Programmer timing
  localparam int T_PWR_WAIT_NS = 40000;
  localparam int T_PE_HOLD_NS = 10000;
  localparam int T_SETTLE_NS = 300000;
  localparam int T_SCI_HALF_NS = 110;
  localparam int PWR_CYC = (T_PWR_WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (T_PE_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_CYC = (T_SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCI_HALF_CYC = (T_SCI_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int GUARD_CYC = 16;

  // ==========================================================
  // Instruction bytes on serial_instruction_in
  localparam logic [7:0] I_LD_CMD = 8'h4C;
  localparam logic [7:0] I_ADDR_LO = 8'h0C;
  localparam logic [7:0] I_ADDR_HI = 8'h1C;
  localparam logic [7:0] I_DATA_LO = 8'h2C;
  localparam logic [7:0] I_DATA_HI = 8'h3C;
  localparam logic [7:0] I_LATCH_LO = 8'h6D;
  localparam logic [7:0] I_LATCH_HI = 8'h7D;
  localparam logic [7:0] I_ARM_LO = 8'h64;
  localparam logic [7:0] I_ARM_HI = 8'h74;
  localparam logic [7:0] I_ARM_EXT = 8'h66;
  localparam logic [7:0] I_FIRE_OFS = 8'h08;
  localparam logic [7:0] I_RD_LO = 8'h68;
  localparam logic [7:0] I_RD_HI = 8'h78;
  localparam logic [7:0] I_RD_FHI = 8'h7A;
  localparam logic [7:0] I_RD_FEXT = 8'h6A;

  // ==========================================================
  // Command bytes loaded with I_LD_CMD
  localparam logic [7:0] C_NOP = 8'h00;
  localparam logic [7:0] C_ERASE = 8'h80;
  localparam logic [7:0] C_WFLASH = 8'h10;
  localparam logic [7:0] C_RFLASH = 8'h02;
  localparam logic [7:0] C_WEE = 8'h11;
  localparam logic [7:0] C_REE = 8'h03;
  localparam logic [7:0] C_WFUSE = 8'h40;
  localparam logic [7:0] C_WLOCK = 8'h20;
  localparam logic [7:0] C_RFUSE = 8'h04;
  localparam logic [7:0] C_RSIG = 8'h08;

  // ==========================================================
  // Fuse layout and reset values
  localparam int EE_PRESERVE_BIT = 3;
  localparam logic [7:0] FUSE_LO_RST = 8'hFF;
  localparam logic [7:0] FUSE_HI_RST = 8'hFF;
  localparam logic [7:0] FUSE_EXT_RST = 8'hFF;
  localparam logic [1:0] LOCK_RST = 2'h3;
  // Identity bytes: arbitrary values
  localparam logic [23:0] SIG_BYTES = 24'h5A_A5_3C;
  localparam logic [7:0] CAL_BYTE = 8'h80;

  typedef enum logic [2:0] {
    HVP_OFF = 3'b000,
    HVP_LATCH = 3'b001,
    HVP_READY = 3'b011,
    HVP_BUSY = 3'b010,
    HVP_LOCK = 3'b110,
    HVP_REJECT = 3'b100
  } hvp_dev_st_t;

  typedef enum logic [2:0] {
    HVP_OP_NONE = 3'h0,
    HVP_OP_ERASE = 3'h1,
    HVP_OP_FLASH = 3'h2,
    HVP_OP_EE = 3'h3,
    HVP_OP_FLO = 3'h4,
    HVP_OP_FHI = 3'h5,
    HVP_OP_FEXT = 3'h6,
    HVP_OP_LOCK = 3'h7
  } hvp_op_t;

  typedef enum logic [3:0] {
    HVP_H_OFF = 4'b0000,
    HVP_H_PWR = 4'b0001,
    HVP_H_HOLD = 4'b0011,
    HVP_H_SETTLE = 4'b0010,
    HVP_H_IDLE = 4'b0110,
    HVP_H_LOW = 4'b0111,
    HVP_H_HIGH = 4'b0101,
    HVP_H_GUARD = 4'b0100,
    HVP_H_POLL = 4'b1100
  } hvp_host_st_t;

endpackage

/* verilog/hvp_if.sv */
// Pin-level link between programmer and device
`timescale 1ns/1ps
interface hvp_if;
  logic hv_reset;
  logic serial_clock_in;
  logic serial_data_in;
  logic serial_instruction_in;
  logic pe2_o;
  logic pe2_oe;
  logic sdo_o;
  logic sdo_oe;
  logic pe2_line;

  // Shared pin: device output wins, weak pull-up when nobody drives
  assign pe2_line = sdo_oe ? sdo_o : (pe2_oe ? pe2_o : 1'b1);

  modport dev (
    input hv_reset, serial_clock_in, serial_data_in, serial_instruction_in, pe2_line,
    output sdo_o, sdo_oe
  );
  modport host (
    output hv_reset, serial_clock_in, serial_data_in, serial_instruction_in, pe2_o, pe2_oe,
    input pe2_line
  );
endinterface

/* verilog/hvp_device.sv */
// Device end: mode entry, frame decoder, page buffers and memories
`timescale 1ns/1ps

// Functional notes
// - Programmer starts with signature pins at 000
// - Programmer raises high reset 20-60 us later
// - Programmer holds signature pins 10 us
// - Device latches signature after 100 ns high
// - Programmer releases signature bit 2 afterwards
// - Programmer waits 300 us before instructions
// - Slow supply: early high reset, then wait; the programmer has only the normal entry sequence
// - Reset to zero ends programming mode
// - Device samples inputs on serial clock rise
// - Command and address stay until reloaded
// - High address byte stays until reloaded
// - Chip erase clears flash, EEPROM, lock bits
// - Lock bits cleared after flash erase only
// - Preserve fuse keeps EEPROM over chip erase
// - Programmer erases before reprogramming memories
// - Erase done shows as high serial output
// - Flash page buffer written as whole page
// - Flash write loop: fill, program, poll
// - EEPROM write loop: fill, program, poll
// - Read flash returns low and high bytes
// - Read EEPROM returns addressed byte
// - Eleven-bit frames on both serial inputs
// - EEPROM page writes loaded bytes, no pre-erase
module hvp_device
  import hvp_pkg::*;
#(
  parameter int FLASH_AW = 12,
  parameter int FPAGE_AW = 3,
  parameter int EE_AW = 9,
  parameter int EPAGE_AW = 2,
  parameter int FLASH_PROG_CYC = hvp_pkg::FLASH_CYC,
  parameter int EE_PROG_CYC = hvp_pkg::EE_CYC,
  parameter int ERASE_PROG_CYC = hvp_pkg::ERASE_CYC
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  hvp_if.dev link,
  output logic prog_mode_out,
  output logic busy_out
);
  import hvp_pkg::*;

  localparam int FW = 2 ** FLASH_AW;
  localparam int FPW = 2 ** FPAGE_AW;
  localparam int EW = 2 ** EE_AW;
  localparam int EPW = 2 ** EPAGE_AW;

  if (FLASH_AW > 16 || EE_AW > 16 || FPAGE_AW > 8 || EPAGE_AW > 8 ||
      FPAGE_AW >= FLASH_AW || EPAGE_AW >= EE_AW) begin : g_chk_aw
    $error("hvp_device: address widths out of range");
  end
  if (FLASH_PROG_CYC < 1 || EE_PROG_CYC < 1 || ERASE_PROG_CYC < 1 ||
      FLASH_PROG_CYC >= 2 ** 20 || EE_PROG_CYC >= 2 ** 20 ||
      ERASE_PROG_CYC >= 2 ** 20) begin : g_chk_cyc
    $error("hvp_device: program cycle counts out of range");
  end

  // ==========================================================
  // Pin synchronisers: bits are pe2, sii, sdi, sci, hv
  logic [4:0] s1_q, s2_q, s3_q, f_q;
  logic sci_prev_q;
  logic sci_rise;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      s1_q <= 5'h00;
      s2_q <= 5'h00;
      s3_q <= 5'h00;
      f_q <= 5'h00;
      sci_prev_q <= 1'b0;
    end else begin
      s1_q <= {link.pe2_line, link.serial_instruction_in, link.serial_data_in, link.serial_clock_in, link.hv_reset};
      s2_q <= s1_q;
      s3_q <= s2_q;
      // A change counts only once two stages agree
      for (int i = 0; i < 5; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          f_q[i] <= s3_q[i];
        end
      end
      sci_prev_q <= f_q[1];
    end
  end

  assign sci_rise = f_q[1] & ~sci_prev_q;

  // ==========================================================
  // Mode control and program cycle timer
  hvp_dev_st_t st_q;
  logic [19:0] cnt_q;
  hvp_op_t op_q;
  logic [10:0] sdi_sh_q, sii_sh_q;
  logic [3:0] bit_q;
  logic [1:0] arm_q;
  logic [7:0] cmd_q, alo_q, ahi_q, dlo_q, dhi_q;
  logic [10:0] sdi_full, sii_full;
  logic [7:0] d, ins;
  logic exec, fire, done;
  hvp_op_t op_new;

  assign sdi_full = {sdi_sh_q[9:0], f_q[2]};
  assign sii_full = {sii_sh_q[9:0], f_q[3]};
  assign d = sdi_full[9:2];
  assign ins = sii_full[9:2];
  assign exec = (st_q == HVP_READY) && sci_rise &&
    (bit_q == 4'(FRAME_BITS - 1));
  assign fire = exec && (arm_q != 2'h0) && (op_new != HVP_OP_NONE) &&
    (ins == (arm_code(arm_q) + I_FIRE_OFS));
  assign done = (st_q == HVP_BUSY) && (cnt_q == 20'h00000);

  function automatic logic [7:0] arm_code(input logic [1:0] a);
    case (a)
      2'h1: arm_code = I_ARM_LO;
      2'h2: arm_code = I_ARM_HI;
      default: arm_code = I_ARM_EXT;
    endcase
  endfunction

  always_comb begin
    case (cmd_q)
      C_ERASE: op_new = HVP_OP_ERASE;
      C_WFLASH: op_new = HVP_OP_FLASH;
      C_WEE: op_new = HVP_OP_EE;
      C_WLOCK: op_new = HVP_OP_LOCK;
      C_WFUSE: begin
        op_new = (arm_q == 2'h1) ? HVP_OP_FLO :
          (arm_q == 2'h2) ? HVP_OP_FHI : HVP_OP_FEXT;
      end
      default: op_new = HVP_OP_NONE;
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= HVP_OFF;
      cnt_q <= 20'h00000;
      op_q <= HVP_OP_NONE;
    end else if (!f_q[0]) begin
      st_q <= HVP_OFF;
    end else begin
      case (st_q)
        HVP_OFF: begin
          st_q <= HVP_LATCH;
          cnt_q <= 20'(HV_LATCH_CYC - 1);
        end
        HVP_LATCH: begin
          if (cnt_q != 20'h00000) begin
            cnt_q <= cnt_q - 20'h00001;
          end else if (f_q[4:2] == 3'b000) begin
            st_q <= HVP_READY;
          end else begin
            st_q <= HVP_REJECT;
          end
        end
        HVP_READY: begin
          if (fire) begin
            st_q <= HVP_BUSY;
            op_q <= op_new;
            cnt_q <= (op_new == HVP_OP_ERASE) ? 20'(ERASE_PROG_CYC - 1) :
              (op_new == HVP_OP_FLASH) ? 20'(FLASH_PROG_CYC - 1) :
              20'(EE_PROG_CYC - 1);
          end
        end
        HVP_BUSY: begin
          if (done) begin
            // Lock bits return to LOCK_RST one cycle after the arrays are clear
            st_q <= (op_q == HVP_OP_ERASE) ? HVP_LOCK : HVP_READY;
          end else begin
            cnt_q <= cnt_q - 20'h00001;
          end
        end
        HVP_LOCK: st_q <= HVP_READY;
        HVP_REJECT: st_q <= HVP_REJECT;
        default: st_q <= HVP_OFF;
      endcase
    end
  end

  // ==========================================================
  // Frame receiver and command/address holding
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sdi_sh_q <= 11'h000;
      sii_sh_q <= 11'h000;
      bit_q <= 4'h0;
    end else if (st_q != HVP_READY) begin
      // Frames shifted while busy are dropped; the host polls first
      bit_q <= 4'h0;
    end else if (sci_rise) begin
      sdi_sh_q <= sdi_full;
      sii_sh_q <= sii_full;
      bit_q <= exec ? 4'h0 : bit_q + 4'h1;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cmd_q <= C_NOP;
      alo_q <= 8'h00;
      ahi_q <= 8'h00;
      dlo_q <= 8'hFF;
      dhi_q <= 8'hFF;
      arm_q <= 2'h0;
    end else if (exec) begin
      // Load registers are only overwritten by their own load frame; arm_q is rewritten by every frame
      case (ins)
        I_LD_CMD: cmd_q <= d;
        I_ADDR_LO: alo_q <= d;
        I_ADDR_HI: ahi_q <= d;
        I_DATA_LO: dlo_q <= d;
        I_DATA_HI: dhi_q <= d;
        default: ;
      endcase
      arm_q <= (ins == I_ARM_LO) ? 2'h1 : (ins == I_ARM_HI) ? 2'h2 :
        (ins == I_ARM_EXT) ? 2'h3 : 2'h0;
    end
  end

  // ==========================================================
  // Memories, page buffers, fuses and lock bits
  logic [15:0] flash_q [FW];
  logic [7:0] ee_q [EW];
  logic [15:0] pbuf_q [FPW];
  logic [7:0] ebuf_q [EPW];
  logic [EPW-1:0] emask_q;
  logic [7:0] fuse_lo_q, fuse_hi_q, fuse_ext_q;
  logic [1:0] lock_q;
  logic [15:0] addr;
  logic [FLASH_AW-1:0] fidx;
  logic [EE_AW-1:0] eidx;

  assign addr = {ahi_q, alo_q};
  assign fidx = addr[FLASH_AW-1:0];
  assign eidx = addr[EE_AW-1:0];

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < FW; i++) flash_q[i] <= 16'hFFFF;
      for (int i = 0; i < EW; i++) ee_q[i] <= 8'hFF;
      for (int i = 0; i < FPW; i++) pbuf_q[i] <= 16'hFFFF;
      for (int i = 0; i < EPW; i++) ebuf_q[i] <= 8'hFF;
      emask_q <= '0;
      fuse_lo_q <= FUSE_LO_RST;
      fuse_hi_q <= FUSE_HI_RST;
      fuse_ext_q <= FUSE_EXT_RST;
      lock_q <= LOCK_RST;
    end else begin
      if (exec && ins == I_LATCH_LO && cmd_q == C_WFLASH) begin
        pbuf_q[fidx[FPAGE_AW-1:0]][7:0] <= dlo_q;
      end
      if (exec && ins == I_LATCH_HI && cmd_q == C_WFLASH) begin
        pbuf_q[fidx[FPAGE_AW-1:0]][15:8] <= dhi_q;
      end
      if (exec && ins == I_LATCH_LO && cmd_q == C_WEE) begin
        ebuf_q[eidx[EPAGE_AW-1:0]] <= dlo_q;
        emask_q[eidx[EPAGE_AW-1:0]] <= 1'b1;
      end
      if (done) begin
        case (op_q)
          HVP_OP_FLASH: begin
            // Writes only clear bits; erased words take the data as is
            for (int i = 0; i < FPW; i++) begin
              flash_q[{fidx[FLASH_AW-1:FPAGE_AW], i[FPAGE_AW-1:0]}] <=
                flash_q[{fidx[FLASH_AW-1:FPAGE_AW], i[FPAGE_AW-1:0]}] &
                pbuf_q[i];
              pbuf_q[i] <= 16'hFFFF;
            end
          end
          HVP_OP_EE: begin
            for (int i = 0; i < EPW; i++) begin
              if (emask_q[i]) begin
                ee_q[{eidx[EE_AW-1:EPAGE_AW], i[EPAGE_AW-1:0]}] <=
                  ee_q[{eidx[EE_AW-1:EPAGE_AW], i[EPAGE_AW-1:0]}] &
                  ebuf_q[i];
              end
              ebuf_q[i] <= 8'hFF;
            end
            emask_q <= '0;
          end
          HVP_OP_ERASE: begin
            for (int i = 0; i < FW; i++) flash_q[i] <= 16'hFFFF;
            if (fuse_hi_q[EE_PRESERVE_BIT]) begin
              for (int i = 0; i < EW; i++) ee_q[i] <= 8'hFF;
            end
          end
          HVP_OP_FLO: fuse_lo_q <= dlo_q;
          HVP_OP_FHI: fuse_hi_q <= dlo_q;
          HVP_OP_FEXT: fuse_ext_q <= dlo_q;
          HVP_OP_LOCK: lock_q <= lock_q & dlo_q[1:0];
          default: ;
        endcase
      end
      if (st_q == HVP_LOCK) begin
        lock_q <= LOCK_RST;
      end
    end
  end

  // ==========================================================
  // Read data select and serial output
  logic [7:0] rd_byte;
  logic rd_hit;
  logic [10:0] out_q;
  logic sdo_q, sdo_oe_q;

  always_comb begin
    rd_hit = 1'b1;
    rd_byte = 8'hFF;
    case ({cmd_q, ins})
      {C_RFLASH, I_RD_LO}: rd_byte = flash_q[fidx][7:0];
      {C_RFLASH, I_RD_HI}: rd_byte = flash_q[fidx][15:8];
      {C_REE, I_RD_LO}: rd_byte = ee_q[eidx];
      {C_RFUSE, I_RD_LO}: rd_byte = fuse_lo_q;
      {C_RFUSE, I_RD_FHI}: rd_byte = fuse_hi_q;
      {C_RFUSE, I_RD_FEXT}: rd_byte = fuse_ext_q;
      {C_RFUSE, I_RD_HI}: rd_byte = {6'h3F, lock_q};
      {C_RSIG, I_RD_LO}: begin
        rd_byte = (alo_q[1:0] == 2'h0) ? SIG_BYTES[23:16] :
          (alo_q[1:0] == 2'h1) ? SIG_BYTES[15:8] : SIG_BYTES[7:0];
      end
      {C_RSIG, I_RD_HI}: rd_byte = CAL_BYTE;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      out_q <= 11'h7FF;
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else begin
      if (exec && rd_hit) begin
        out_q <= {rd_byte, 3'h7};
      end else if (st_q == HVP_READY && sci_rise) begin
        out_q <= {out_q[9:0], 1'b1};
      end else if (st_q != HVP_READY) begin
        out_q <= 11'h7FF;
      end
      // Pin stays released until the signature has been latched
      sdo_oe_q <= (st_q == HVP_READY) || (st_q == HVP_BUSY) ||
        (st_q == HVP_LOCK);
      sdo_q <= (st_q == HVP_READY) && out_q[10];
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      prog_mode_out <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      prog_mode_out <= sdo_oe_q;
      busy_out <= (st_q == HVP_BUSY) || (st_q == HVP_LOCK);
    end
  end

  assign link.sdo_o = sdo_q;
  assign link.sdo_oe = sdo_oe_q;

endmodule

/* verilog/hvp_programmer.sv */
// Programmer end: entry sequence, frame shifter and ready polling
`timescale 1ns/1ps
module hvp_programmer
  import hvp_pkg::*;
#(
  parameter int PWR_WAIT_CYC = hvp_pkg::PWR_CYC,
  parameter int PE_HOLD_CYC = hvp_pkg::HOLD_CYC,
  parameter int SETTLE_WAIT_CYC = hvp_pkg::SETTLE_CYC,
  parameter int HALF_CYC = 8
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  hvp_if.host link,
  input wire logic enter_in,
  input wire logic exit_in,
  input wire logic frm_valid_in,
  input wire logic [7:0] frm_data_in,
  input wire logic [7:0] frm_instr_in,
  input wire logic frm_poll_in,
  output logic frm_ready_out,
  output logic rsp_valid_out,
  output logic [7:0] rsp_data_out,
  output logic session_out
);
  import hvp_pkg::*;

  // Half periods below this would let the device miss the sampled bit
  if (HALF_CYC < SCI_HALF_CYC || HALF_CYC < 8 || PWR_WAIT_CYC < 1 ||
      PE_HOLD_CYC < 1 || SETTLE_WAIT_CYC < 1 ||
      SETTLE_WAIT_CYC >= 2 ** 24) begin : g_chk
    $error("hvp_programmer: timing parameters out of range");
  end

  // ==========================================================
  // Serial output synchroniser
  logic s1_q, s2_q, s3_q, sdo_f_q;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      sdo_f_q <= 1'b0;
    end else begin
      s1_q <= link.pe2_line;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        sdo_f_q <= s3_q;
      end
    end
  end

  // ==========================================================
  // Sequencer
  hvp_host_st_t st_q;
  logic [23:0] cnt_q;
  logic [3:0] bit_q;
  logic [10:0] tx_d_q, tx_i_q, rx_q;
  logic poll_q, hv_q, sci_q, sdi_q, sii_q, pe2_oe_q;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= HVP_H_OFF;
      cnt_q <= 24'h000000;
      bit_q <= 4'h0;
      tx_d_q <= 11'h000;
      tx_i_q <= 11'h000;
      rx_q <= 11'h000;
      poll_q <= 1'b0;
      hv_q <= 1'b0;
      sci_q <= 1'b0;
      sdi_q <= 1'b0;
      sii_q <= 1'b0;
      pe2_oe_q <= 1'b1;
      frm_ready_out <= 1'b0;
      rsp_valid_out <= 1'b0;
      rsp_data_out <= 8'h00;
      session_out <= 1'b0;
    end else begin
      rsp_valid_out <= 1'b0;
      if (cnt_q != 24'h000000) begin
        cnt_q <= cnt_q - 24'h000001;
      end
      if (exit_in && st_q != HVP_H_OFF) begin
        // Dropping reset ends the session at once
        st_q <= HVP_H_OFF;
        hv_q <= 1'b0;
        sci_q <= 1'b0;
        sdi_q <= 1'b0;
        sii_q <= 1'b0;
        pe2_oe_q <= 1'b1;
        frm_ready_out <= 1'b0;
        session_out <= 1'b0;
      end else begin
        case (st_q)
          HVP_H_OFF: begin
            if (enter_in) begin
              st_q <= HVP_H_PWR;
              cnt_q <= 24'(PWR_WAIT_CYC - 1);
            end
          end
          HVP_H_PWR: begin
            if (cnt_q == 24'h000000) begin
              hv_q <= 1'b1;
              st_q <= HVP_H_HOLD;
              cnt_q <= 24'(PE_HOLD_CYC - 1);
            end
          end
          HVP_H_HOLD: begin
            if (cnt_q == 24'h000000) begin
              pe2_oe_q <= 1'b0;
              st_q <= HVP_H_SETTLE;
              cnt_q <= 24'(SETTLE_WAIT_CYC - 1);
            end
          end
          HVP_H_SETTLE: begin
            if (cnt_q == 24'h000000) begin
              st_q <= HVP_H_IDLE;
              frm_ready_out <= 1'b1;
              session_out <= 1'b1;
            end
          end
          HVP_H_IDLE: begin
            if (frm_valid_in) begin
              tx_d_q <= {1'b0, frm_data_in, 2'h0};
              tx_i_q <= {1'b0, frm_instr_in, 2'h0};
              poll_q <= frm_poll_in;
              frm_ready_out <= 1'b0;
              bit_q <= 4'h0;
              st_q <= HVP_H_LOW;
              cnt_q <= 24'(HALF_CYC - 1);
            end
          end
          HVP_H_LOW: begin
            sci_q <= 1'b0;
            sdi_q <= tx_d_q[10];
            sii_q <= tx_i_q[10];
            if (cnt_q == 24'h000000) begin
              rx_q <= {rx_q[9:0], sdo_f_q};
              sci_q <= 1'b1;
              st_q <= HVP_H_HIGH;
              cnt_q <= 24'(HALF_CYC - 1);
            end
          end
          HVP_H_HIGH: begin
            if (cnt_q == 24'h000000) begin
              sci_q <= 1'b0;
              tx_d_q <= {tx_d_q[9:0], 1'b0};
              tx_i_q <= {tx_i_q[9:0], 1'b0};
              bit_q <= bit_q + 4'h1;
              cnt_q <= 24'(HALF_CYC - 1);
              if (bit_q == 4'(FRAME_BITS - 1)) begin
                rsp_valid_out <= 1'b1;
                rsp_data_out <= rx_q[10:3];
                if (poll_q) begin
                  st_q <= HVP_H_GUARD;
                  cnt_q <= 24'(GUARD_CYC - 1);
                end else begin
                  st_q <= HVP_H_IDLE;
                  frm_ready_out <= 1'b1;
                end
              end else begin
                st_q <= HVP_H_LOW;
              end
            end
          end
          HVP_H_GUARD: begin
            // The stale high level must fade before polling starts
            if (cnt_q == 24'h000000) begin
              st_q <= HVP_H_POLL;
            end
          end
          HVP_H_POLL: begin
            if (sdo_f_q) begin
              st_q <= HVP_H_IDLE;
              frm_ready_out <= 1'b1;
            end
          end
          default: st_q <= HVP_H_OFF;
        endcase
      end
    end
  end

  assign link.hv_reset = hv_q;
  assign link.serial_clock_in = sci_q;
  assign link.serial_data_in = sdi_q;
  assign link.serial_instruction_in = sii_q;
  assign link.pe2_o = 1'b0;
  assign link.pe2_oe = pe2_oe_q;

endmodule

/* tb/hvp_properties.sv */
// Concurrent checks on the pins between programmer and device
`timescale 1ns/1ps
module hvp_properties (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic hv_reset,
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  input wire logic serial_instruction_in,
  input wire logic pe2_oe,
  input wire logic sdo_oe,
  input wire logic sdo_o,
  input wire logic pe2_line
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // Cycles the high voltage has stood, for the signature hold
  int hv_cyc_q;
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) hv_cyc_q <= 0;
    else hv_cyc_q <= hv_reset ? hv_cyc_q + 1 : 0;
  end
  // ==========================================================
  // Entry and exit
  a_entry_pins_low: assert property (
    $rose(hv_reset) |-> !serial_data_in && !serial_instruction_in && !pe2_line)
    else $error("entry signature not zero");
  a_hold_before_release: assert property (
    $fell(pe2_oe) |-> hv_cyc_q >= hvp_pkg::HOLD_CYC)
    else $error("signature pin released too early");
  a_no_early_drive: assert property (
    $rose(hv_reset) |-> !sdo_oe [*3])
    else $error("device drove output before latch");
  a_quiet_clock_entry: assert property (
    pe2_oe |-> !serial_clock_in)
    else $error("serial clock moved during entry");
  a_release_on_exit: assert property (
    !hv_reset [*8] |-> !sdo_oe)
    else $error("output still driven after exit");
  // ==========================================================
  // Frame timing
  a_bits_stable_rise: assert property (
    $rose(serial_clock_in) |-> $stable(serial_data_in) && $stable(serial_instruction_in))
    else $error("data moved at clock rise");
  a_sci_high_width: assert property (
    $rose(serial_clock_in) |-> serial_clock_in [*8])
    else $error("serial clock high too short");
  a_sci_low_width: assert property (
    $fell(serial_clock_in) |-> !serial_clock_in [*8])
    else $error("serial clock low too short");
  cover property ($rose(hv_reset));
  cover property ($rose(sdo_oe));
  cover property (sdo_oe && $rose(sdo_o));
endmodule

/* tb/high_voltage_serial_programmer_port_bench.sv */
// Bench joining programmer and device ends over the link
`timescale 1ns/1ps
module high_voltage_serial_programmer_port_bench;
  import hvp_pkg::*;
  logic clk_sys_in = 0, rst_in = 1, enter_in = 0, exit_in = 0;
  logic frm_valid_in = 0, frm_poll_in = 0, frm_ready_out, rsp_valid_out;
  logic session_out, prog_mode_out, busy_out;
  logic [7:0] frm_data_in = 8'h00, frm_instr_in = 8'h00, rsp_data_out, ee;
  logic [7:0] wd [8];
  int errors = 0, check_count = 0;
  hvp_if link ();
  // Short program cycles keep the run small
  hvp_device #(.FLASH_PROG_CYC(20), .EE_PROG_CYC(20), .ERASE_PROG_CYC(20))
    hvp_device_i (.clk_sys_in, .rst_in, .link(link.dev), .prog_mode_out,
    .busy_out);
  hvp_programmer #(.PWR_WAIT_CYC(10))
    hvp_programmer_i (.clk_sys_in, .rst_in, .link(link.host), .enter_in,
    .exit_in, .frm_valid_in, .frm_data_in, .frm_instr_in, .frm_poll_in,
    .frm_ready_out, .rsp_valid_out, .rsp_data_out, .session_out);
  hvp_properties hvp_properties_i (.clk_sys_in, .rst_in,
    .hv_reset(link.hv_reset), .serial_clock_in(link.serial_clock_in), .serial_data_in(link.serial_data_in), .serial_instruction_in(link.serial_instruction_in),
    .pe2_oe(link.pe2_oe), .sdo_oe(link.sdo_oe), .sdo_o(link.sdo_o),
    .pe2_line(link.pe2_line));
  always #12.5 clk_sys_in = ~clk_sys_in;
  // ==========================================================
  // Tasks
  task automatic end_of_test();
    if (errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask
  function automatic logic [7:0] lock_byte(input logic [1:0] l);
    return {6'h3F, l};
  endfunction
  task automatic frm(input logic [7:0] i, d, input logic p = 1'b0);
    @(negedge clk_sys_in);
    {frm_valid_in, frm_instr_in, frm_data_in, frm_poll_in} = {1'b1, i, d, p};
    while (frm_ready_out !== 1'b1) @(negedge clk_sys_in);
    @(negedge clk_sys_in);
    frm_valid_in = 0;
    while (frm_ready_out !== 1'b1) @(negedge clk_sys_in);
  endtask
  // Read data leaves the device in the frame after the read frame
  task automatic rd(input logic [7:0] a, b, e);
    frm(a, 8'h00);
    frm(b, 8'h00);
    chk({7'h00, rsp_valid_out}, 8'h01);
    chk(rsp_data_out, e);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'hD92422D7));
    foreach (wd[k]) wd[k] = 8'($urandom);
    ee = 8'($urandom);
    repeat (10) @(negedge clk_sys_in);
    rst_in = 0;
    enter_in = 1;
    @(negedge clk_sys_in) enter_in = 0;
    while (session_out !== 1'b1) @(negedge clk_sys_in);
    chk({7'h00, prog_mode_out}, 8'h01);
    frm(I_LD_CMD, C_RFUSE);
    rd(I_RD_LO, 8'h6C, FUSE_LO_RST);
    rd(I_RD_FHI, 8'h7C, FUSE_HI_RST);
    frm(I_LD_CMD, C_WLOCK);
    frm(I_DATA_LO, 8'h00);
    frm(I_ARM_LO, 8'h00);
    frm(8'h6C, 8'h00, 1'b1);
    frm(I_LD_CMD, C_RFUSE);
    rd(I_RD_HI, 8'h7C, lock_byte(2'h0));
    frm(I_LD_CMD, C_ERASE);
    frm(I_ARM_LO, 8'h00);
    frm(8'h6C, 8'h00, 1'b1);
    frm(I_LD_CMD, C_RFUSE);
    rd(I_RD_HI, 8'h7C, lock_byte(LOCK_RST));
    frm(I_LD_CMD, C_WFLASH);
    for (int k = 0; k < 8; k++) begin
      frm(I_ADDR_LO, 8'(k));
      frm(I_DATA_LO, wd[k]);
      frm(I_DATA_HI, ~wd[k]);
      frm(I_LATCH_LO, 8'h00);
      frm(I_LATCH_HI, 8'h00);
    end
    frm(I_ADDR_HI, 8'h00);
    frm(I_ARM_LO, 8'h00);
    frm(8'h6C, 8'h00, 1'b1);
    frm(I_LD_CMD, C_RFLASH);
    for (int k = 0; k < 9; k++) begin
      frm(I_ADDR_LO, 8'(k));
      rd(I_RD_LO, 8'h6C, k < 8 ? wd[k % 8] : 8'hFF);
      rd(I_RD_HI, 8'h7C, k < 8 ? ~wd[k % 8] : 8'hFF);
    end
    frm(I_LD_CMD, C_WEE);
    frm(I_ADDR_LO, 8'h05);
    frm(I_ADDR_HI, 8'h00);
    frm(I_DATA_LO, ee);
    frm(I_LATCH_LO, 8'h00);
    frm(I_ARM_LO, 8'h00);
    frm(8'h6C, 8'h00, 1'b1);
    frm(I_LD_CMD, C_REE);
    rd(I_RD_LO, 8'h6C, ee);
    frm(I_ADDR_LO, 8'h04);
    rd(I_RD_LO, 8'h6C, 8'hFF);
    frm(I_LD_CMD, C_WFUSE);
    frm(I_DATA_LO, ~(8'h01 << EE_PRESERVE_BIT));
    frm(I_ARM_HI, 8'h00);
    frm(8'h7C, 8'h00, 1'b1);
    frm(I_LD_CMD, C_ERASE);
    frm(I_ARM_LO, 8'h00);
    frm(8'h6C, 8'h00, 1'b1);
    frm(I_LD_CMD, C_REE);
    frm(I_ADDR_LO, 8'h05);
    rd(I_RD_LO, 8'h6C, ee);
    frm(I_LD_CMD, C_RFLASH);
    rd(I_RD_LO, 8'h6C, 8'hFF);
    exit_in = 1;
    @(negedge clk_sys_in) exit_in = 0;
    while (prog_mode_out !== 1'b0) @(negedge clk_sys_in);
    chk({7'h00, busy_out}, 8'h00);
    end_of_test();
  end
  // A hung handshake ends the run as a failure
  initial begin
    #(25 * 80000);
    errors++;
    end_of_test();
  end
endmodule
